// ===== design/host_cmd_sts_pkg.sv
// Purpose: Shared constants for the host command and status registers
// Assumes: 100 MHz sys_clk, 32-bit register words
// Notes: Offsets are byte addresses on the processor port
`default_nettype none
package host_cmd_sts_pkg;
  // Register map
  localparam logic [7:0] CMD_OFFSET = 8'h20;
  localparam logic [7:0] STS_OFFSET = 8'h24;
  // Command fields
  localparam int RUN_BIT = 0;
  localparam int FULL_RST_BIT = 1;
  localparam int LIGHT_RST_BIT = 7;
  localparam int RATE_LSB = 16;
  localparam int RATE_MSB = 23;
  localparam logic [7:0] RATE_RESET = 8'h08;
  // Status fields
  localparam int PORT_CHG_BIT = 2;
  localparam int WRAP_BIT = 3;
  localparam int HALTED_BIT = 12;
  localparam int NUM_PORTS = 3;
  // Full reset duration
  localparam int CLK_PERIOD_NS = 10;
  localparam int FULL_RESET_NS = 320;
  localparam int FULL_RESET_CYCLES = (FULL_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] FULL_RESET_LAST = CNT_W'(FULL_RESET_CYCLES - 1);
  // Reset sequencer, Gray along idle -> full/light -> idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FULL = 2'b01,
    ST_LIGHT = 2'b10
  } rst_state_t;
endpackage
`default_nettype wire

// ===== design/reg_wr_if.sv
// Purpose: Write strobes and core reset shared by the register slices
// Assumes: One clock domain
// Notes: ctl_reset is driven by the command slice only
`timescale 1ns/100ps
`default_nettype none
interface reg_wr_if;
  logic wr_cmd;
  logic wr_sts;
  logic [31:0] wdata;
  logic ctl_reset;
  modport src (output wr_cmd, output wr_sts, output wdata, input ctl_reset);
  modport cmd (input wr_cmd, input wdata, output ctl_reset);
  modport sts (input wr_sts, input wdata, input ctl_reset);
endinterface
`default_nettype wire

// ===== design/host_cmd_reg.sv
// Purpose: Command register with run control and reset sequencer
// Assumes: Writes come from the decoder on sys_clk
// Notes: Writes during a reset sequence are ignored
`timescale 1ns/100ps
`default_nettype none
module host_cmd_reg
  import host_cmd_sts_pkg::*;
#(
  parameter bit LIGHT_IMPL = 1'b1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  reg_wr_if.cmd bus,
  output logic run_stop,
  output logic [7:0] irq_rate_limit,
  output logic full_busy,
  output logic light_busy
);
  rst_state_t state, next_state;
  logic [CNT_W-1:0] count;
  logic write_full;
  logic light_req;

  assign write_full = bus.wr_cmd && bus.wdata[FULL_RST_BIT];
  assign light_req = bus.wr_cmd && bus.wdata[LIGHT_RST_BIT] && LIGHT_IMPL && !write_full;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (write_full) begin
          next_state = ST_FULL;
        end else if (light_req) begin
          next_state = ST_LIGHT;
        end
      end
      ST_FULL: begin
        if (count == FULL_RESET_LAST) begin
          next_state = ST_IDLE;
        end
      end
      ST_LIGHT: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (state == ST_FULL) begin
      count <= count + 1'b1;
    end else begin
      count <= '0;
    end
  end

  assign full_busy = (state == ST_FULL);
  assign light_busy = (state == ST_LIGHT);
  assign bus.ctl_reset = full_busy || light_busy;

  ////////////////////////////////////////////////////////////////////////
  // Written bits act on the next edge, not just stored
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_stop <= 1'b0;
      irq_rate_limit <= RATE_RESET;
    end else if (state != ST_IDLE || write_full || light_req) begin
      run_stop <= 1'b0;
      irq_rate_limit <= RATE_RESET;
    end else if (bus.wr_cmd) begin
      run_stop <= bus.wdata[RUN_BIT];
      irq_rate_limit <= bus.wdata[RATE_MSB:RATE_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  localparam int full_span = FULL_RESET_CYCLES;

  sequence full_req_s;
    write_full && state == ST_IDLE;
  endsequence
  sequence full_body_s;
    full_busy [*8] ##[1:full_span] !full_busy;
  endsequence

  chk_cmd_write_apply: assert property (
    bus.wr_cmd && state == ST_IDLE && !write_full && !light_req |=>
      run_stop == $past(bus.wdata[RUN_BIT]) && irq_rate_limit == $past(bus.wdata[RATE_MSB:RATE_LSB]))
    else $error("command write not applied");
  chk_rate_default: assert property (
    state != ST_IDLE |=> irq_rate_limit == RATE_RESET)
    else $error("rate field not back at default");
  chk_light_reset_core: assert property (
    light_req && state == ST_IDLE |=> light_busy && !run_stop ##1 !light_busy)
    else $error("light reset sequence wrong");
  chk_full_reset_span: assert property (
    full_req_s |=> full_body_s)
    else $error("full reset did not run and end");
  chk_full_reset_len: assert property (
    $fell(full_busy) |-> $past(count) == FULL_RESET_LAST)
    else $error("full reset length wrong");
  chk_stop_in_reset: assert property (
    full_busy ##1 full_busy |-> !run_stop)
    else $error("schedule runs during reset");
endmodule
`default_nettype wire

// ===== design/host_sts_flags.sv
// Purpose: Sticky status flags with write-one-to-clear
// Assumes: Event inputs are one-cycle pulses on sys_clk
// Notes: A set in the clearing cycle wins
`timescale 1ns/100ps
`default_nettype none
module host_sts_flags
  import host_cmd_sts_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  reg_wr_if.sts bus,
  input wire logic frame_list_wrap,
  input wire logic [NUM_PORTS-1:0] port_change,
  input wire logic [NUM_PORTS-1:0] companion_handoff_flag,
  input wire logic [NUM_PORTS-1:0] force_resume_rise,
  output logic frame_list_wrap_flag,
  output logic port_change_flag
);
  logic set_port;
  logic clr_wrap;
  logic clr_port;

  // Changes on ports handed to a companion do not count; resumes always do
  assign set_port = |(port_change & ~companion_handoff_flag) || |force_resume_rise;
  assign clr_wrap = bus.wr_sts && bus.wdata[WRAP_BIT];
  assign clr_port = bus.wr_sts && bus.wdata[PORT_CHG_BIT];

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_list_wrap_flag <= 1'b0;
    end else if (bus.ctl_reset) begin
      frame_list_wrap_flag <= 1'b0;
    end else begin
      frame_list_wrap_flag <= frame_list_wrap || (frame_list_wrap_flag && !clr_wrap);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_change_flag <= 1'b0;
    end else if (bus.ctl_reset) begin
      port_change_flag <= 1'b0;
    end else begin
      port_change_flag <= set_port || (port_change_flag && !clr_port);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  chk_wrap_sets: assert property (
    frame_list_wrap && !bus.ctl_reset |=> frame_list_wrap_flag)
    else $error("wrap flag not set");
  chk_port_sets: assert property (
    set_port && !bus.ctl_reset |=> port_change_flag)
    else $error("port change flag not set");
  chk_flag_keep: assert property (
    frame_list_wrap_flag && !bus.ctl_reset && !clr_wrap |=> frame_list_wrap_flag)
    else $error("wrap flag lost without a one written");
  chk_flag_clear: assert property (
    clr_port && !set_port |=> !port_change_flag)
    else $error("port flag not cleared by a one");
endmodule
`default_nettype wire

// ===== design/host_cmd_status.sv
// Purpose: Command and status register pair of the host controller
// Assumes: Processor port is synchronous to sys_clk
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Command writes take effect immediately
// - Bits 23:16 set interrupt rate, default 8
// - Bit 7 light reset spares port state
// - Absent light reset reads bit 7 zero
// - Writing one to bit 1 resets controller
// - Bit 0 runs or stops the schedule
// - Status shows interrupts and states, not transactions
// - Flags clear on written one or controller reset
// - Bit 3 set on frame list wrap
// - Bit 2 set on port change or resume
// - Enabled flag raises interrupt, cleared by software
module host_cmd_status
  import host_cmd_sts_pkg::*;
#(
  parameter bit LIGHT_IMPL = 1'b1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] bus_addr,
  input wire logic bus_cs,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic frame_list_wrap,
  input wire logic [NUM_PORTS-1:0] port_change,
  input wire logic [NUM_PORTS-1:0] companion_handoff_flag,
  input wire logic [NUM_PORTS-1:0] force_resume_rise,
  input wire logic wrap_irq_enable,
  input wire logic port_irq_enable,
  input wire logic uframe_tick,
  output logic schedule_run,
  output logic core_reset,
  output logic port_reset,
  output logic irq
);
  reg_wr_if wr ();
  logic run_stop;
  logic [7:0] irq_rate_limit;
  logic full_busy;
  logic light_busy;
  logic frame_list_wrap_flag;
  logic port_change_flag;
  logic [31:0] cmd_word;
  logic [31:0] sts_word;
  logic pending;
  logic [7:0] rate_count;

  ////////////////////////////////////////////////////////////////////////
  // Decode; reserved write bits are masked by the slices, not trusted
  assign wr.wr_cmd = bus_cs && bus_wr && bus_addr == CMD_OFFSET;
  assign wr.wr_sts = bus_cs && bus_wr && bus_addr == STS_OFFSET;
  assign wr.wdata = bus_wdata;

  host_cmd_reg #(
    .LIGHT_IMPL(LIGHT_IMPL)
  ) u_cmd (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .bus(wr.cmd),
    .run_stop(run_stop),
    .irq_rate_limit(irq_rate_limit),
    .full_busy(full_busy),
    .light_busy(light_busy)
  );

  host_sts_flags u_sts (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .bus(wr.sts),
    .frame_list_wrap(frame_list_wrap),
    .port_change(port_change),
    .companion_handoff_flag(companion_handoff_flag),
    .force_resume_rise(force_resume_rise),
    .frame_list_wrap_flag(frame_list_wrap_flag),
    .port_change_flag(port_change_flag)
  );

  assign schedule_run = run_stop;
  assign core_reset = wr.ctl_reset;
  assign port_reset = full_busy;

  ////////////////////////////////////////////////////////////////////////
  // Read words
  assign cmd_word = {8'h00, irq_rate_limit, 8'h00, LIGHT_IMPL && light_busy, 5'h00, full_busy, run_stop};
  // Only halt state and event flags; no transaction results
  assign sts_word = {19'h00000, !run_stop, 8'h00, frame_list_wrap_flag, port_change_flag, 2'h0};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= 32'h00000000;
    end else if (bus_cs && bus_rd) begin
      case (bus_addr)
        CMD_OFFSET: bus_rdata <= cmd_word;
        STS_OFFSET: bus_rdata <= sts_word;
        default: bus_rdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= bus_cs && bus_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt gating and rate limit in microframes
  assign pending = (frame_list_wrap_flag && wrap_irq_enable) || (port_change_flag && port_irq_enable);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_count <= 8'h00;
    end else if (!pending) begin
      rate_count <= 8'h00;
    end else if (uframe_tick && rate_count != 8'hff) begin
      rate_count <= rate_count + 8'h01;
    end
  end

  // Held while pending, so clearing the flag is the acknowledge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= pending && rate_count >= irq_rate_limit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence cmd_read_s;
    bus_cs && bus_rd && bus_addr == CMD_OFFSET;
  endsequence
  sequence sts_read_s;
    bus_cs && bus_rd && bus_addr == STS_OFFSET;
  endsequence

  chk_light_absent_zero: assert property (
    (!LIGHT_IMPL) and cmd_read_s |=> !bus_rdata[LIGHT_RST_BIT])
    else $error("absent light reset reads one");
  chk_reserved_zero: assert property (
    sts_read_s |=> bus_rvalid && bus_rdata[31:13] == 19'h00000 && bus_rdata[11:4] == 8'h00 &&
      bus_rdata[1:0] == 2'h0 && bus_rdata[HALTED_BIT] == !$past(run_stop))
    else $error("status reserved bits wrong");
  chk_cmd_reserved: assert property (
    cmd_read_s |=> bus_rdata[31:24] == 8'h00 && bus_rdata[15:8] == 8'h00 && bus_rdata[6:2] == 5'h00)
    else $error("command reserved bits not zero");
  chk_irq_prompt: assert property (
    pending && irq_rate_limit == 8'h00 |=> irq)
    else $error("enabled flag raised no interrupt");
  chk_irq_quiet: assert property (
    !pending |=> !irq)
    else $error("interrupt without enabled flag");
endmodule
`default_nettype wire

// ===== bench/event_source_model.sv
// Purpose: Event and interrupt-enable source beside the host registers
// Assumes: Driven on rising sys_clk by non-blocking assignment
// Notes: Microframe tick every 4 cycles keeps rate tests short
`timescale 1ns/100ps
`default_nettype none
module event_source_model
  import host_cmd_sts_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic frame_list_wrap,
  output logic [NUM_PORTS-1:0] port_change,
  output logic [NUM_PORTS-1:0] companion_handoff_flag,
  output logic [NUM_PORTS-1:0] force_resume_rise,
  output logic wrap_irq_enable,
  output logic port_irq_enable,
  output logic uframe_tick
);
  logic [1:0] tick_cnt;
  initial begin
    frame_list_wrap = 1'b0;
    port_change = '0;
    companion_handoff_flag = '0;
    force_resume_rise = '0;
    wrap_irq_enable = 1'b0;
    port_irq_enable = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt <= 2'h0;
    end else begin
      tick_cnt <= tick_cnt + 2'h1;
    end
  end
  assign uframe_tick = (tick_cnt == 2'h3);
  ////////////////////////////////////////////////////////////
  // One-cycle pulses, as the flag logic expects
  task automatic pulse(input logic w, input logic [NUM_PORTS-1:0] pc, input logic [NUM_PORTS-1:0] fr);
    @(posedge sys_clk);
    frame_list_wrap <= w;
    port_change <= pc;
    force_resume_rise <= fr;
    @(posedge sys_clk);
    frame_list_wrap <= 1'b0;
    port_change <= '0;
    force_resume_rise <= '0;
  endtask
  task automatic levels(input logic [NUM_PORTS-1:0] ho, input logic we, input logic pe);
    @(posedge sys_clk);
    companion_handoff_flag <= ho;
    wrap_irq_enable <= we;
    port_irq_enable <= pe;
  endtask
endmodule
`default_nettype wire

// ===== bench/host_cmd_status_tb_top.sv
// Purpose: Self-checking bench for the command and status registers
// Assumes: One access per two cycles from the bus tasks
// Notes: Second instance has the light reset left out
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
  if ((got) !== (exp)) begin \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    failures++; \
  end \
  check_count++; \
end
module host_cmd_status_tb_top
  import host_cmd_sts_pkg::*;
;
  logic sys_clk;
  logic reset_n;
  logic [7:0] bus_addr;
  logic bus_cs;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_wdata;
  wire logic [31:0] bus_rdata;
  wire logic [31:0] bus_rdata2;
  wire logic bus_rvalid;
  wire logic frame_list_wrap;
  wire logic [NUM_PORTS-1:0] port_change;
  wire logic [NUM_PORTS-1:0] companion_handoff_flag;
  wire logic [NUM_PORTS-1:0] force_resume_rise;
  wire logic wrap_irq_enable;
  wire logic port_irq_enable;
  wire logic uframe_tick;
  wire logic schedule_run;
  wire logic core_reset;
  wire logic port_reset;
  wire logic irq;
  int failures;
  int check_count;
  int n;
  int pn;
  ////////////////////////////////////////////////////////////
  host_cmd_status #(.LIGHT_IMPL(1'b1)) host_cmd_status_inst (.sys_clk, .reset_n, .bus_addr,
    .bus_cs, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .bus_rvalid, .frame_list_wrap,
    .port_change, .companion_handoff_flag, .force_resume_rise, .wrap_irq_enable,
    .port_irq_enable, .uframe_tick, .schedule_run, .core_reset, .port_reset, .irq);
  host_cmd_status #(.LIGHT_IMPL(1'b0)) host_cmd_status_inst2 (.sys_clk, .reset_n, .bus_addr,
    .bus_cs, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata(bus_rdata2), .bus_rvalid(),
    .frame_list_wrap, .port_change, .companion_handoff_flag, .force_resume_rise,
    .wrap_irq_enable, .port_irq_enable, .uframe_tick, .schedule_run(), .core_reset(),
    .port_reset(), .irq());
  event_source_model event_source_model_inst (.sys_clk, .reset_n, .frame_list_wrap,
    .port_change, .companion_handoff_flag, .force_resume_rise, .wrap_irq_enable,
    .port_irq_enable, .uframe_tick);
  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Reserved bits always written as zero by these callers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_cs <= 1'b1;
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_cs <= 1'b0;
    bus_wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    bus_cs <= 1'b1;
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_cs <= 1'b0;
    bus_rd <= 1'b0;
    #1;
    `CHK({bus_rvalid, bus_rdata}, {1'b1, e})
  endtask
  task automatic wait_irq(input logic e, input int maxc);
    int k;
    k = 0;
    // Off the launching edge, so irq has settled
    #1;
    while (irq !== e && k < maxc) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    `CHK(irq, e)
  endtask
  // Cycles of core_reset, and of port_reset within them
  task automatic reset_len();
    int k;
    n = 0;
    pn = 0;
    k = 0;
    #1;
    while (core_reset !== 1'b1 && k < 3) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    while (core_reset === 1'b1 && n < 100) begin
      n++;
      if (port_reset === 1'b1) pn++;
      @(posedge sys_clk);
      #1;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #50000;
    failures++;
    print_verdict();
  end
  initial begin
    failures = 0;
    check_count = 0;
    reset_n = 1'b0;
    bus_addr = 8'h00;
    bus_cs = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk_rd(CMD_OFFSET, 32'h00080000);
    chk_rd(STS_OFFSET, 32'h00001000);
    chk_rd(8'h28, 32'h00000000);
    wr(CMD_OFFSET, 32'h00100001);
    @(posedge sys_clk);
    #1;
    `CHK(schedule_run, 1'b1)
    chk_rd(CMD_OFFSET, 32'h00100001);
    chk_rd(STS_OFFSET, 32'h00000000);
    // Change on a handed-off port must not count
    event_source_model_inst.levels(3'b001, 1'b0, 1'b0);
    event_source_model_inst.pulse(1'b1, 3'b001, 3'b000);
    chk_rd(STS_OFFSET, 32'h00000008);
    wr(STS_OFFSET, 32'h00000000);
    chk_rd(STS_OFFSET, 32'h00000008);
    event_source_model_inst.pulse(1'b0, 3'b010, 3'b000);
    chk_rd(STS_OFFSET, 32'h0000000c);
    wr(STS_OFFSET, 32'h00000004);
    chk_rd(STS_OFFSET, 32'h00000008);
    event_source_model_inst.pulse(1'b0, 3'b000, 3'b100);
    chk_rd(STS_OFFSET, 32'h0000000c);
    wr(STS_OFFSET, 32'h00000008);
    wr(CMD_OFFSET, 32'h00000001);
    event_source_model_inst.levels(3'b000, 1'b1, 1'b0);
    wait_irq(1'b0, 2);
    event_source_model_inst.levels(3'b000, 1'b1, 1'b1);
    wait_irq(1'b1, 3);
    wr(STS_OFFSET, 32'h00000004);
    wait_irq(1'b0, 3);
    // Three ticks at four cycles each hold the request back
    wr(CMD_OFFSET, 32'h00030001);
    event_source_model_inst.pulse(1'b1, 3'b000, 3'b000);
    repeat (8) @(posedge sys_clk);
    wait_irq(1'b0, 0);
    wait_irq(1'b1, 30);
    wr(CMD_OFFSET, 32'h00000002);
    reset_len();
    `CHK(n, FULL_RESET_CYCLES)
    `CHK(pn, FULL_RESET_CYCLES)
    `CHK(schedule_run, 1'b0)
    chk_rd(CMD_OFFSET, 32'h00080000);
    chk_rd(STS_OFFSET, 32'h00001000);
    wr(CMD_OFFSET, 32'h00100001);
    wr(CMD_OFFSET, 32'h00100080);
    reset_len();
    `CHK(n, 1)
    `CHK(pn, 0)
    chk_rd(CMD_OFFSET, 32'h00080000);
    `CHK(bus_rdata2, 32'h00100000)
    print_verdict();
  end
endmodule
`default_nettype wire
